// >>> logic/dcs_port.sv
// Port logic of the burst-of-four common-I/O DDR SRAM: link side and array.
`timescale 1ns/100ps

module dcs_port
  import dcs_pkg::*;
#(
  parameter int AW = 20,  // Burst word address width.
  parameter int NB = 2,   // Byte lanes per beat.
  parameter int IW = 6    // Index width of the flip-flop array.
) (
  input  logic                      clock,                 // System clock.
  input  logic                      reset_n,               // Synchronous reset, active low.
  input  logic                      link_clk,              // True input clock; its fall is the complement edge.
  input  logic                      dll_bypass_n,          // Low selects one-cycle read latency.
  input  logic                      new_address_strobe_n,  // Low defines a new bus sequence.
  input  logic                      read_not_write,        // High reads, low writes.
  input  logic [AW-1:0]             address,               // Starting burst address.
  input  logic [NB-1:0]             byte_lane_enable_n,    // Low stores the lane.
  input  logic [NB*DCS_LANE_W-1:0]  dq_in,                 // Data bus as seen at the pins.
  output logic [NB*DCS_LANE_W-1:0]  dq_out,                // Data driven onto the bus.
  output logic                      dq_oe_n,               // Low while the bus is driven.
  output logic [1:0]                echo_timer_pair,       // Echo clocks, true in bit 0.
  input  logic [DCS_IMP_W-1:0]      impedance_ref_pin,     // Digitised impedance reference.
  output logic [DCS_IMP_W-1:0]      drive_impedance        // Driver impedance code.
);

  localparam int DW = NB * DCS_LANE_W;  // Data width of one beat.

  // Apply the stored-lane mask of one beat to an array word.
  function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old_w,
                                               input logic [DW-1:0] new_w,
                                               input logic [NB-1:0] en_n);
    logic [DW-1:0] res;
    res = old_w;
    for (int b = 0; b < NB; b++) begin
      if (!en_n[b]) begin
        res[b*DCS_LANE_W +: DCS_LANE_W] = new_w[b*DCS_LANE_W +: DCS_LANE_W];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Declarations
  logic                 rst_s1_r;                 // Reset synchroniser, first stage.
  logic                 rst_s2_r;                 // Reset synchroniser, second stage.
  logic                 byp_s1_r;                 // Bypass pin, first stage.
  logic                 byp_s2_r;                 // Bypass pin, second stage.
  logic                 done_s1_r;                // Settled flag, first stage.
  logic                 done_s2_r;                // Settled flag, second stage.
  logic                 link_rst_n;               // Reset as seen by the link side.
  logic [DCS_IMP_W-1:0] cal_code;                 // Code from the settling logic.
  logic                 cal_done;                 // Settled flag in the system domain.
  logic                 cmd;                      // Command accepted this edge.
  logic                 busy_r, busy_nxt;         // Second cycle of a burst slot.
  logic [DCS_PIPE_D:1]  pv_r, pv_nxt;             // Command valid per age.
  logic [DCS_PIPE_D:1]  pr_r, pr_nxt;             // Command was a read.
  logic [DCS_PIPE_D:1]  pb_r, pb_nxt;             // Read taken in bypass mode.
  logic [AW-1:0]        pa_r   [1:DCS_PIPE_D];    // Command address per age.
  logic [AW-1:0]        pa_nxt [1:DCS_PIPE_D];
  logic [DW-1:0]        rbuf_r   [0:DCS_BURST-1]; // Read burst staging.
  logic [DW-1:0]        rbuf_nxt [0:DCS_BURST-1];
  logic [DW-1:0]        fw [0:DCS_BURST-1];       // Fetched, snooped read words.
  logic [AW-1:0]        fa [0:DCS_BURST-1];       // Read beat addresses.
  logic [AW-1:0]        ca [0:DCS_BURST-1];       // Commit beat addresses.
  logic [DW-1:0]        cb [0:DCS_BURST-1];       // Commit beat data.
  logic [NB-1:0]        cm [0:DCS_BURST-1];       // Commit beat lane enables.
  logic                 cap_byp, cap_norm;        // Read capture this edge.
  logic [AW-1:0]        cap_addr;                 // Start address being captured.
  logic                 commit;                   // Write buffer goes to the array.
  logic [DW-1:0]        mem_r   [0:(1<<IW)-1];    // Storage array.
  logic [DW-1:0]        mem_nxt [0:(1<<IW)-1];
  logic [DW-1:0]        wev_r   [0:1];            // Beats 0 and 2 of the write.
  logic [DW-1:0]        wev_nxt [0:1];
  logic [NB-1:0]        wem_r   [0:1];            // Their lane enables.
  logic [NB-1:0]        wem_nxt [0:1];
  logic [DW-1:0]        wod_r   [0:1];            // Beats 1 and 3 of the write.
  logic [DW-1:0]        wod_nxt [0:1];
  logic [NB-1:0]        wom_r   [0:1];            // Their lane enables.
  logic [NB-1:0]        wom_nxt [0:1];
  logic [DW-1:0]        q_pos_r, q_pos_nxt;       // Beat launched on the true edge.
  logic                 pos_val_r, pos_val_nxt;   // That beat is valid.
  logic [DW-1:0]        q_neg_r, q_neg_nxt;       // Beat launched on the complement edge.
  logic                 neg_val_r, neg_val_nxt;   // That beat is valid.
  logic [DCS_IMP_W-1:0] imp_r, imp_nxt;           // Code applied at the drivers.

  // ==========================================================================
  // Impedance settling on the system clock
  dcs_imp_cal u_cal (
    .clock     (clock),
    .reset_n   (reset_n),
    .ref_level (impedance_ref_pin),
    .cal_code  (cal_code),
    .cal_done  (cal_done)
  );

  // ==========================================================================
  // Synchronisers into the link domain
  // Reset, bypass pin and settled flag each pass two flops.
  always_ff @(posedge link_clk) begin
    rst_s1_r  <= reset_n;
    rst_s2_r  <= rst_s1_r;
    byp_s1_r  <= dll_bypass_n;
    byp_s2_r  <= byp_s1_r;
    done_s1_r <= cal_done;
    done_s2_r <= done_s1_r;
  end

  assign link_rst_n = rst_s2_r;

  // ==========================================================================
  // Command decode
  // A low strobe starts a burst unless the slot is still busy.
  assign cmd = ~new_address_strobe_n & ~busy_r;

  // Commit view of the write buffer, beats in burst order.
  always_comb begin
    for (int j = 0; j < DCS_BURST; j++) begin
      ca[j] = pa_r[DCS_AGE_CMT] + AW'(j);
      cb[j] = j[0] ? wod_r[j>>1] : wev_r[j>>1];
      cm[j] = j[0] ? wom_r[j>>1] : wem_r[j>>1];
    end
  end

  assign commit   = pv_r[DCS_AGE_CMT] & ~pr_r[DCS_AGE_CMT];
  assign cap_byp  = pv_r[DCS_AGE_BYP] & pr_r[DCS_AGE_BYP] & pb_r[DCS_AGE_BYP];
  assign cap_norm = pv_r[DCS_AGE_CAP] & pr_r[DCS_AGE_CAP] & ~pb_r[DCS_AGE_CAP];
  assign cap_addr = cap_byp ? pa_r[DCS_AGE_BYP] : pa_r[DCS_AGE_CAP];

  // Read fetch: array word, overlaid by a commit landing on the same edge.
  always_comb begin
    for (int i = 0; i < DCS_BURST; i++) begin
      fa[i] = cap_addr + AW'(i);
      fw[i] = mem_r[fa[i][IW-1:0]];
      for (int j = 0; j < DCS_BURST; j++) begin
        if (commit && (ca[j] == fa[i])) begin
          fw[i] = lane_merge(fw[i], cb[j], cm[j]);
        end
      end
    end
  end

  // ==========================================================================
  // True-edge logic: command pipe, read launch, write beats, commit
  always_comb begin
    busy_nxt = cmd;
    // Each command walks the pipe, one age per true edge.
    pv_nxt   = {pv_r[DCS_PIPE_D-1:1], cmd};
    pr_nxt   = {pr_r[DCS_PIPE_D-1:1], read_not_write};
    pb_nxt   = {pb_r[DCS_PIPE_D-1:1], ~byp_s2_r};
    pa_nxt[1] = address;
    for (int k = 2; k <= DCS_PIPE_D; k++) begin
      pa_nxt[k] = pa_r[k-1];
    end
    // A read takes its four words at capture time.
    rbuf_nxt = rbuf_r;
    if (cap_byp || cap_norm) begin
      rbuf_nxt = fw;
    end
    // True-edge beats: 1 and 3 normally, 0 and 2 in bypass.
    q_pos_nxt   = q_pos_r;
    pos_val_nxt = 1'b0;
    if (cap_byp) begin
      q_pos_nxt   = fw[0];
      pos_val_nxt = 1'b1;
    end else if (pv_r[DCS_AGE_BYP+1] && pr_r[DCS_AGE_BYP+1] && pb_r[DCS_AGE_BYP+1]) begin
      q_pos_nxt   = rbuf_r[2];
      pos_val_nxt = 1'b1;
    end else if (pv_r[DCS_AGE_CAP+1] && pr_r[DCS_AGE_CAP+1] && !pb_r[DCS_AGE_CAP+1]) begin
      q_pos_nxt   = rbuf_r[1];
      pos_val_nxt = 1'b1;
    end else if (pv_r[DCS_AGE_CAP+2] && pr_r[DCS_AGE_CAP+2] && !pb_r[DCS_AGE_CAP+2]) begin
      q_pos_nxt   = rbuf_r[3];
      pos_val_nxt = 1'b1;
    end
    // Write beats 0 and 2, each with the lane enables of its own edge.
    wev_nxt = wev_r;
    wem_nxt = wem_r;
    if (pv_r[DCS_AGE_WD0] && !pr_r[DCS_AGE_WD0]) begin
      wev_nxt[0] = dq_in;
      wem_nxt[0] = byte_lane_enable_n;
    end
    if (pv_r[DCS_AGE_WD2] && !pr_r[DCS_AGE_WD2]) begin
      wev_nxt[1] = dq_in;
      wem_nxt[1] = byte_lane_enable_n;
    end
    // The buffered burst reaches the array in its third cycle.
    mem_nxt = mem_r;
    if (commit) begin
      for (int j = 0; j < DCS_BURST; j++) begin
        mem_nxt[ca[j][IW-1:0]] = lane_merge(mem_r[ca[j][IW-1:0]], cb[j], cm[j]);
      end
    end
    // Drivers take the final code only once it is frozen.
    imp_nxt = done_s2_r ? cal_code : imp_r;
    // Reset clears control state; data storage keeps its contents.
    if (!link_rst_n) begin
      busy_nxt    = 1'b0;
      pv_nxt      = '0;
      pr_nxt      = '0;
      pb_nxt      = '0;
      q_pos_nxt   = '0;
      pos_val_nxt = 1'b0;
      imp_nxt     = DCS_IMP_MID;
    end
  end

  // Registers only.
  always_ff @(posedge link_clk) begin
    busy_r    <= busy_nxt;
    pv_r      <= pv_nxt;
    pr_r      <= pr_nxt;
    pb_r      <= pb_nxt;
    pa_r      <= pa_nxt;
    rbuf_r    <= rbuf_nxt;
    q_pos_r   <= q_pos_nxt;
    pos_val_r <= pos_val_nxt;
    wev_r     <= wev_nxt;
    wem_r     <= wem_nxt;
    mem_r     <= mem_nxt;
    imp_r     <= imp_nxt;
  end

  // ==========================================================================
  // Complement-edge logic: read beats and write beats 1 and 3
  // The pipe has already moved one age on, so indices sit one higher.
  always_comb begin
    q_neg_nxt   = q_neg_r;
    neg_val_nxt = 1'b0;
    if (pv_r[DCS_AGE_CAP+1] && pr_r[DCS_AGE_CAP+1] && !pb_r[DCS_AGE_CAP+1]) begin
      q_neg_nxt   = rbuf_r[0];
      neg_val_nxt = 1'b1;
    end else if (pv_r[DCS_AGE_CAP+2] && pr_r[DCS_AGE_CAP+2] && !pb_r[DCS_AGE_CAP+2]) begin
      q_neg_nxt   = rbuf_r[2];
      neg_val_nxt = 1'b1;
    end else if (pv_r[DCS_AGE_BYP+1] && pr_r[DCS_AGE_BYP+1] && pb_r[DCS_AGE_BYP+1]) begin
      q_neg_nxt   = rbuf_r[1];
      neg_val_nxt = 1'b1;
    end else if (pv_r[DCS_AGE_BYP+2] && pr_r[DCS_AGE_BYP+2] && pb_r[DCS_AGE_BYP+2]) begin
      q_neg_nxt   = rbuf_r[3];
      neg_val_nxt = 1'b1;
    end
    // Odd write beats follow their true-edge partners by half a cycle.
    wod_nxt = wod_r;
    wom_nxt = wom_r;
    if (pv_r[DCS_AGE_WD0+1] && !pr_r[DCS_AGE_WD0+1]) begin
      wod_nxt[0] = dq_in;
      wom_nxt[0] = byte_lane_enable_n;
    end
    if (pv_r[DCS_AGE_WD2+1] && !pr_r[DCS_AGE_WD2+1]) begin
      wod_nxt[1] = dq_in;
      wom_nxt[1] = byte_lane_enable_n;
    end
    if (!link_rst_n) begin
      q_neg_nxt   = '0;
      neg_val_nxt = 1'b0;
    end
  end

  // Registers only.
  always_ff @(negedge link_clk) begin
    q_neg_r   <= q_neg_nxt;
    neg_val_r <= neg_val_nxt;
    wod_r     <= wod_nxt;
    wom_r     <= wom_nxt;
  end

  // ==========================================================================
  // Pins
  // Each half cycle shows the beat launched on the edge that opened it.
  assign dq_out          = link_clk ? q_pos_r : q_neg_r;
  // The bus floats whenever no beat is launched, so it releases by itself.
  assign dq_oe_n         = link_clk ? ~pos_val_r : ~neg_val_r;
  // Echo clocks run free and share the data's launch edges.
  assign echo_timer_pair = {~link_clk, link_clk};
  assign drive_impedance = imp_r;

  // ==========================================================================
  // Checks
  default clocking cb_link @(posedge link_clk);
  endclocking
  default disable iff (!link_rst_n);

  sequence s_norm_beats;
    neg_val_r ##1 (pos_val_r && neg_val_r) ##1 pos_val_r;
  endsequence

  sequence s_byp_beats;
    (pos_val_r && neg_val_r) ##1 (pos_val_r && neg_val_r);
  endsequence

  AST_READ_LATENCY: assert property (
    (pv_r[1] && pr_r[1] && !pb_r[1]) |-> ##2 s_norm_beats)
    else $error("Normal read beats not on the 2.5 cycle schedule.");

  AST_BYP_LATENCY: assert property (
    (pv_r[1] && pr_r[1] && pb_r[1]) |-> ##1 s_byp_beats)
    else $error("Bypass read beats not on the one cycle schedule.");

  AST_READ_RELEASE: assert property (
    (pv_r[4] && pr_r[4] && !pb_r[4] && byp_s2_r && !(pv_r[2] && pr_r[2]) && !pv_r[1])
      |-> ##2 (!pos_val_r && !neg_val_r))
    else $error("Bus still driven after the last read beat.");

  // The busy edge takes nothing, and the command address reaches the commit age intact.
  AST_CMD_SPACING: assert property (
    pv_r[1] |=> !pv_r[1] ##1 (pv_r[DCS_AGE_CMT] && pa_r[DCS_AGE_CMT] == $past(pa_r[1], 2)))
    else $error("Busy slot took a command or the pipe lost the address.");

  AST_ADDR_CAPTURE: assert property (
    (!new_address_strobe_n && !busy_r) |=> pv_r[1] && pa_r[1] == $past(address))
    else $error("Low strobe did not register the address.");

  // The word under a read at commit age must come through that edge unchanged.
  AST_NO_STORE_ON_READ: assert property (
    (pv_r[DCS_AGE_CMT] && pr_r[DCS_AGE_CMT])
      |=> mem_r[$past(pa_r[DCS_AGE_CMT][IW-1:0])] == $past(mem_r[pa_r[DCS_AGE_CMT][IW-1:0]]))
    else $error("Array written for a read command.");

  AST_WRITE_COMMIT: assert property (
    (commit && wem_r[0] == '0) |=> mem_r[$past(ca[0][IW-1:0])] == $past(wev_r[0]))
    else $error("First write beat not committed in the third cycle.");

  AST_BYTE_MASK: assert property (
    (commit && wem_r[0][0] && ca[1] != ca[0] && ca[2] != ca[0] && ca[3] != ca[0])
      |=> mem_r[$past(ca[0][IW-1:0])][DCS_LANE_W-1:0]
          == $past(mem_r[ca[0][IW-1:0]][DCS_LANE_W-1:0]))
    else $error("Disabled lane was stored.");

endmodule

// >>> logic/dcs_pkg.sv
// Shared constants and types for the burst-of-four DDR SRAM port.
package dcs_pkg;

  // ==========================================================================
  // Data and burst layout
  localparam int DCS_LANE_W = 9;  // Bits per byte lane.
  localparam int DCS_BURST  = 4;  // Beats per access, reads and writes alike.

  // ==========================================================================
  // Pipeline ages, in true-clock edges after the command edge
  localparam int DCS_PIPE_D  = 4;  // Deepest age tracked.
  localparam int DCS_AGE_BYP = 1;  // Bypass-mode capture and first beat.
  localparam int DCS_AGE_CAP = 2;  // Normal-mode capture of the read burst.
  localparam int DCS_AGE_WD0 = 1;  // First write beat on the true edge.
  localparam int DCS_AGE_WD2 = 2;  // Third write beat on the true edge.
  localparam int DCS_AGE_CMT = 3;  // Write buffer commit to the array.

  // ==========================================================================
  // Output impedance settling
  localparam int                   DCS_IMP_W          = 6;      // Driver code width.
  localparam logic [DCS_IMP_W-1:0] DCS_IMP_MID        = 6'h20;  // Code after reset.
  localparam int                   DCS_IMP_SETTLE_CYC = 1024;   // Cycles to final code.
  localparam int                   DCS_CNT_W          = 11;     // Settle counter width.
  localparam logic [DCS_CNT_W-1:0] DCS_SETTLE_LAST    = DCS_CNT_W'(DCS_IMP_SETTLE_CYC - 1);

  // Settling state machine.
  typedef enum logic {
    DCS_CAL_SETTLE = 1'b0,
    DCS_CAL_DONE   = 1'b1
  } dcs_cal_e;

endpackage

// >>> logic/dcs_imp_cal.sv
// Power-up settling of the output driver impedance code.
`timescale 1ns/100ps
module dcs_imp_cal
  import dcs_pkg::*;
(
  input  logic                 clock,      // System clock.
  input  logic                 reset_n,    // Synchronous reset, active low.
  input  logic [DCS_IMP_W-1:0] ref_level,  // Digitised level of the impedance pin.
  output logic [DCS_IMP_W-1:0] cal_code,   // Driver code, mid-range until settled.
  output logic                 cal_done    // High once the final code stands.
);

  // ==========================================================================
  // State
  logic [DCS_IMP_W-1:0] ref_s1_r;   // First stage of the pin synchroniser.
  logic [DCS_IMP_W-1:0] ref_s2_r;   // Second stage, the only one read.
  logic [DCS_CNT_W-1:0] cnt_r;      // Cycles spent settling.
  logic [DCS_CNT_W-1:0] cnt_nxt;
  dcs_cal_e             state_r;    // Settling or done.
  dcs_cal_e             state_nxt;
  logic [DCS_IMP_W-1:0] code_r;     // Code presented to the drivers.
  logic [DCS_IMP_W-1:0] code_nxt;

  // The pin level is asynchronous, so it passes two flops first.
  always_ff @(posedge clock) begin
    ref_s1_r <= ref_level;
    ref_s2_r <= ref_s1_r;
  end

  // Hold mid-range, then take the final code once and keep it stable.
  // Keeping it frozen lets the link side copy it on a synchronised flag.
  always_comb begin
    cnt_nxt   = cnt_r;
    state_nxt = state_r;
    code_nxt  = code_r;
    case (state_r)
      DCS_CAL_SETTLE: begin
        cnt_nxt = cnt_r + DCS_CNT_W'(1);
        if (cnt_r == DCS_SETTLE_LAST) begin
          state_nxt = DCS_CAL_DONE;
          code_nxt  = ref_s2_r;
        end
      end
      DCS_CAL_DONE: begin
        cnt_nxt = cnt_r;
      end
      default: begin
        state_nxt = DCS_CAL_SETTLE;
      end
    endcase
    // Reset starts the driver at the middle of its range.
    if (!reset_n) begin
      cnt_nxt   = '0;
      state_nxt = DCS_CAL_SETTLE;
      code_nxt  = DCS_IMP_MID;
    end
  end

  // Registers only.
  always_ff @(posedge clock) begin
    cnt_r   <= cnt_nxt;
    state_r <= state_nxt;
    code_r  <= code_nxt;
  end

  assign cal_code = code_r;
  assign cal_done = (state_r == DCS_CAL_DONE);

  // ==========================================================================
  // Checks
  AST_IMP_MID: assert property (@(posedge clock) disable iff (!reset_n)
    !cal_done |-> cal_code == DCS_IMP_MID)
    else $error("Driver code left mid-range before settling.");

  AST_IMP_SETTLE: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(cal_done) |-> $past(cnt_r) == DCS_SETTLE_LAST)
    else $error("Impedance settled after the wrong cycle count.");

endmodule

// >>> tb/dcs_ctrl_model.sv
// Memory controller model that drives commands and write data onto the port.
`timescale 1ns/100ps
module dcs_ctrl_model
  import dcs_pkg::*;
(
  input  wire logic        link_clk,              // True input clock.
  input  wire logic [17:0] dq_out,                // Data driven by the device.
  input  wire logic        dq_oe_n,               // Low while the device drives.
  output logic             new_address_strobe_n,  // Command strobe.
  output logic             read_not_write,        // Command direction.
  output logic [19:0]      address,               // Command address.
  output logic [1:0]       byte_lane_enable_n,    // Lane enables of the beat.
  output logic [17:0]      dq_in                  // Resolved bus level.
);
  logic [17:0] drv_d = 18'h0;   // Beat put on the bus.
  logic        drv_en = 1'b0;   // High while the controller drives.
  logic [17:0] flt_d = 18'h0;   // Floating pattern, changes every edge.

  // ==========================================================================
  // Bus resolution: a released bus never keeps its last value.
  always @(link_clk) flt_d <= ~dq_in;
  assign dq_in = !dq_oe_n ? dq_out : (drv_en ? drv_d : flt_d);

  initial begin
    new_address_strobe_n = 1'b1;
    read_not_write = 1'b1;
    address = 20'h0;
    byte_lane_enable_n = 2'h3;
  end

  // ==========================================================================
  // Write: entered just after a true edge; data beats change after the edge before their capture.
  task automatic cmd_write(input logic [19:0] a, input logic [3:0][17:0] d, input logic [3:0][1:0] be);
    new_address_strobe_n = 1'b0;
    read_not_write = 1'b0;
    address = a;
    @(posedge link_clk);
    #2;
    new_address_strobe_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i[0]) @(posedge link_clk);
      else @(negedge link_clk);
      #2;
      drv_en = 1'b1;
      drv_d = d[i];
      byte_lane_enable_n = be[i];
    end
  endtask

  // Read: a stray strobe on the busy edge must be ignored by the device.
  task automatic cmd_read(input logic [19:0] a, input bit stray);
    new_address_strobe_n = 1'b0;
    read_not_write = 1'b1;
    address = a;
    @(posedge link_clk);
    #2;
    new_address_strobe_n = !stray;
    read_not_write = !stray;
    address = ~a;
    drv_en = 1'b0;
    @(posedge link_clk);
    #2;
  endtask

  // Idle cycles with the bus released.
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge link_clk);
      #2;
      drv_en = 1'b0;
      new_address_strobe_n = 1'b1;
    end
  endtask
endmodule

// >>> tb/dcs_port_tb_top.sv
// Self-checking bench of the burst-of-four DDR SRAM port.
`timescale 1ns/100ps
module dcs_port_tb_top
  import dcs_pkg::*;
;
  logic        clock = 1'b0;         // System clock.
  logic        link_clk = 1'b0;      // Link clock.
  logic        reset_n = 1'b0;       // Reset, active low.
  logic        dll_bypass_n = 1'b1;  // Latency mode.
  logic [5:0]  imp_ref = 6'h0;       // Impedance reference.
  wire         strobe_n, rnw, dq_oe_n;
  wire  [19:0] addr;
  wire  [1:0]  ben_n, echo;
  wire  [17:0] dq_in, dq_out;
  wire  [5:0]  drive_imp;
  int          err_total = 0;        // Mismatches.
  int          total_checks = 0;     // Comparisons.
  int          edge_cnt = 0;         // Link edges seen.
  int          seed;                 // Seed return.
  logic [17:0] mem [64];             // Expected array.
  logic [17:0] exp_d [$];            // Expected beats.
  int          exp_e [$];            // Edge of each beat.

  initial forever #25 clock = ~clock;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  dcs_port uut (.clock(clock), .reset_n(reset_n), .link_clk(link_clk), .dll_bypass_n(dll_bypass_n),
    .new_address_strobe_n(strobe_n), .read_not_write(rnw), .address(addr), .byte_lane_enable_n(ben_n),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .echo_timer_pair(echo),
    .impedance_ref_pin(imp_ref), .drive_impedance(drive_imp));
  dcs_ctrl_model ctrl (.link_clk(link_clk), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .new_address_strobe_n(strobe_n), .read_not_write(rnw), .address(addr),
    .byte_lane_enable_n(ben_n), .dq_in(dq_in));

  // ==========================================================================
  // Comparison and verdict.
  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watcher: takes the oldest note whenever a beat is due.
  always @(link_clk) begin
    edge_cnt = edge_cnt + 1;
    #10;
    check("echo", 18'(echo), 18'({~link_clk, link_clk}));
    if (exp_e.size() > 0 && exp_e[0] == edge_cnt) begin
      check("drive enable", 18'(dq_oe_n), 18'h0);
      check("read beat", dq_out, exp_d.pop_front());
      void'(exp_e.pop_front());
    end else if (reset_n) begin
      check("drive enable", 18'(dq_oe_n), 18'h1);
    end
  end

  // ==========================================================================
  // Drivers that note the expected beats.
  task automatic wr(input logic [19:0] a, input bit full);
    logic [3:0][17:0] d;
    logic [3:0][1:0]  be;
    for (int i = 0; i < 4; i++) begin
      d[i] = 18'($urandom);
      be[i] = full ? 2'h0 : 2'($urandom);
      for (int b = 0; b < 2; b++) if (!be[i][b]) mem[6'(a + 20'(i))][b*9 +: 9] = d[i][b*9 +: 9];
    end
    ctrl.cmd_write(a, d, be);
  endtask

  task automatic rd(input logic [19:0] a, input bit stray);
    for (int i = 0; i < 4; i++) begin
      exp_d.push_back(mem[6'(a + 20'(i))]);
      exp_e.push_back(edge_cnt + (dll_bypass_n ? 7 : 4) + i);
    end
    ctrl.cmd_read(a, stray);
  endtask

  initial begin
    #200000;
    err_total++;
    close_out();
  end

  initial begin
    seed = $urandom(59);
    imp_ref = 6'($urandom);
    repeat (20) @(posedge clock);
    #2;
    reset_n = 1'b1;
    fork
      begin
        repeat (4) @(posedge clock);
        check("impedance start", 18'(drive_imp), 18'h20);
        repeat (996) @(posedge clock);
        check("impedance hold", 18'(drive_imp), 18'h20);
        repeat (40) @(posedge clock);
        check("impedance final", 18'(drive_imp), 18'(imp_ref));
      end
    join_none
    repeat (4) @(posedge link_clk);
    #2;
    for (int k = 0; k < 8; k++) wr(20'hffff0 + 20'(4 * k), 1'b1);
    for (int m = 1; m >= 0; m--) begin
      dll_bypass_n = m[0];
      ctrl.idle(4);
      for (int k = 0; k < 6; k++) rd(20'hffff1 + 20'(5 * k), k == 2);
      ctrl.idle(4);
      for (int k = 0; k < 4; k++) begin
        wr(20'hffffe + 20'(3 * k), 1'b0);
        rd(20'hffffe + 20'(3 * k), 1'b0);
        ctrl.idle(3);
      end
    end
    ctrl.idle(6);
    check("beats left", 18'(exp_e.size()), 18'h0);
    wait fork;
    close_out();
  end
endmodule
